// *** hdl/led_regs_pkg.sv ***
// Purpose: shared constants and carriers for the led driver register bank
// Assumes: 24-bit setup and fault words, avalon-mm word registers
// Notes:   register byte address is four times the register index

package led_regs_pkg;

	////////////////////////////////////////////////////////////////////////
	// register indices (byte address = 4 * index)
	localparam logic [2:0] IDX_SETUP      = 3'h0; // channel_setup, write only
	localparam logic [2:0] IDX_FAULT      = 3'h1; // fault_status, read clears
	localparam logic [2:0] IDX_IRQ_STATUS = 3'h2; // sticky events, write one clears
	localparam logic [2:0] IDX_IRQ_MASK   = 3'h3; // event enables
	localparam logic [2:0] IDX_LAST       = 3'h3; // highest mapped index

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int FRAME_BITS    = 24; // serial frame and word width
	localparam int PAIRS         = 8;  // diagnostic pin pairs
	localparam int CHANNELS      = 16; // switched outputs
	localparam int FLAG_BITS     = 18; // fault word bits 23..6
	localparam int FLAG_LSB      = 6;  // lowest flag bit in fault word
	localparam int CRC_BITS      = 6;  // crc remainder width
	localparam int IRQ_BITS      = 3;  // event count
	localparam int IRQ_FAULT_BIT = 0;  // new fault flag raised
	localparam int IRQ_LATCH_BIT = 1;  // setup word latched from serial link
	localparam int IRQ_DOWN_BIT  = 2;  // device left operation

	////////////////////////////////////////////////////////////////////////
	// reset values and constants
	localparam logic [23:0] SETUP_RESET = 24'h00_0000; // all off, plain outputs
	localparam logic [17:0] FLAG_RESET  = 18'h0_0000;  // no faults
	localparam logic [2:0]  MASK_RESET  = 3'h0;        // events masked
	localparam logic [5:0]  CRC_POLY    = 6'h03;       // x^6 + x + 1

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [7:0]  pair_select;   // bit k: pair 2k odd pin is diag input
		logic [15:0] output_switch; // bit n: switch of channel n on
	} setup_s;

	typedef struct packed {
		logic [15:0] led_flags;            // per pair: open above short
		logic        overtemperature_flag; // thermal shutdown seen
		logic        cmd_err_flag;         // diag with odd switch on
		logic [5:0]  crc;                  // remainder of setup word
	} fault_s;

endpackage : led_regs_pkg

// *** hdl/pin_sync.sv ***
// Purpose: three stage synchroniser for pins from outside sys_clk
// Assumes: each bit independent, slow against sys_clk
// Notes:   output moves only once stages two and three agree

`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 1 // number of pins
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] s1_q; // first stage, read only by s2
	logic [WIDTH-1:0] s2_q; // second stage
	logic [WIDTH-1:0] s3_q; // third stage
	logic [WIDTH-1:0] out_d;

	////////////////////////////////////////////////////////////////////////
	// accept a bit only where the last two stages agree
	always_comb begin
		out_d = pin_out;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				out_d[i] = s3_q[i];
			end
		end
	end

	// stage registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			pin_out <= '0;
		end else begin
			s1_q    <= pin_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			pin_out <= out_d;
		end
	end

endmodule : pin_sync

// *** hdl/led_driver_regs.sv ***
// Purpose: register bank, serial link and power states of a 16 channel led driver
// Assumes: link pins, supply and detector levels arrive unsynchronised
// Notes:   registers on avalon-mm, two cycles per access
// Operation
// [R01] supply low stops device, clears state
// [R02] supply high starts device with defaults
// [R03] standby pin high resets registers to defaults
// [R04] setup bits 23..16 select pairs 14..0
// [R05] select high makes odd pin diag input
// [R06] setup register at 0h resets to zero
// [R07] only setup 0h and fault 1h; the code also maps irq status at 2h and irq mask at 3h
// [R08] read clears flags whose fault has gone
// [R09] setup bits 15..0 switch matching channels
// [R10] fault bits 23..8 open/short per pair
// [R11] 24-bit frames msb first, shift and latch
//
// The Avalon-MM register port is this design's own decision.

`timescale 1ns/1ps

module led_driver_regs (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        supply_ok,
	input  wire logic        standby_sel,
	input  wire logic        link_sclk,
	input  wire logic        link_latch,
	input  wire logic        link_sdi,
	output logic             link_sdo,
	input  wire logic [7:0]  led_open_det,
	input  wire logic [7:0]  led_short_det,
	input  wire logic        overtemp_det,
	output logic      [15:0] output_switch_on,
	output logic      [7:0]  diag_input_en,
	output logic             fault_pin_o,
	output logic             fault_pin_oe,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] byte_write(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return r;
	endfunction : byte_write

	// remainder of word followed by six zeros
	function automatic logic [5:0] crc6(input logic [23:0] data);
		logic [5:0] rem;
		logic       fb;
		rem = '0;
		for (int i = 23; i >= 0; i--) begin
			fb  = rem[5] ^ data[i];
			rem = {rem[4:0], 1'b0} ^ (fb ? led_regs_pkg::CRC_POLY : 6'h00);
		end
		return rem;
	endfunction : crc6

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	localparam int SW = 22; // six single pins plus two detector bytes
	logic [SW-1:0] pin_raw; // all foreign pins
	logic [SW-1:0] pin_s;   // filtered copies
	logic          sup_s;   // supply above threshold
	logic          stby_s;  // standby select
	logic          sclk_s;  // link shift clock
	logic          latch_s; // link latch
	logic          sdi_s;   // link data in
	logic          ot_s;    // overtemperature
	logic [7:0]    open_s;  // open detectors per pair
	logic [7:0]    short_s; // short detectors per pair

	assign pin_raw = {supply_ok, standby_sel, link_sclk, link_latch, link_sdi,
		overtemp_det, led_open_det, led_short_det};

	pin_sync #(.WIDTH(SW)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_in  (pin_raw),
		.pin_out (pin_s)
	);

	assign {sup_s, stby_s, sclk_s, latch_s, sdi_s, ot_s, open_s, short_s} = pin_s;

	////////////////////////////////////////////////////////////////////////
	// state
	led_regs_pkg::setup_s setup_q, setup_d;       // channel_setup
	logic [17:0]          flags_q, flags_d;       // fault flags 23..6
	logic                 active_q;               // registered operating state
	logic                 active_d;               // powered and not standby
	logic [23:0]          shift_in_q, shift_in_d;   // write frame
	logic [23:0]          shift_out_q, shift_out_d; // readback frame
	logic                 sclk_prev_q, latch_prev_q;
	logic                 sclk_rise, sclk_fall, latch_rise;
	logic                 waitreq_q, waitreq_d;
	logic [31:0]          rdata_q, rdata_d;
	logic [2:0]           irq_status_q, irq_status_d;
	logic [2:0]           irq_mask_q, irq_mask_d;
	logic                 irq_d;
	logic [15:0]          drain_q, drain_d;       // switches to pins
	logic [7:0]           diag_q, diag_d;         // diag inputs enabled
	logic                 sdo_q, sdo_d;
	logic                 err_oe_q, err_oe_d;

	////////////////////////////////////////////////////////////////////////
	// fault causes and effective pin roles
	logic [7:0]  cmd_err_v;  // select with odd switch on
	logic [7:0]  diag_eff;   // pairs really in diag mode
	logic [7:0]  even_on;    // monitored channel switched on
	logic [15:0] drain_eff;  // switches after thermal cutoff
	logic [15:0] led_cause;  // open/short live per pair
	logic [17:0] cause_v;    // all live causes
	logic [23:0] fault_word; // word as read
	logic [2:0]  bus_idx;    // register index
	logic        bus_req, bus_acc, rd_fault;

	always_comb begin
		for (int k = 0; k < led_regs_pkg::PAIRS; k++) begin
			cmd_err_v[k] = setup_q.pair_select[k] & setup_q.output_switch[2*k+1]; // [R05]
			diag_eff[k]  = setup_q.pair_select[k] & ~cmd_err_v[k];                 // [R04] [R05]
		end
		drain_eff = ot_s ? 16'h0000 : setup_q.output_switch; // [R09]
		for (int k = 0; k < led_regs_pkg::PAIRS; k++) begin
			even_on[k]         = drain_eff[2*k];
			led_cause[2*k+1]   = open_s[k] & diag_eff[k] & even_on[k];  // [R10]
			led_cause[2*k]     = short_s[k] & diag_eff[k] & even_on[k]; // [R10]
		end
		cause_v    = {led_cause, ot_s, |cmd_err_v};
		fault_word = {flags_q, crc6(setup_q)};
	end

	////////////////////////////////////////////////////////////////////////
	// bus decode
	assign bus_idx  = avs_address[4:2];
	assign bus_req  = avs_read | avs_write;
	assign bus_acc  = bus_req & ~waitreq_q;
	assign rd_fault = bus_acc & avs_read & (bus_idx == led_regs_pkg::IDX_FAULT);

	// serial edges from filtered pins
	assign sclk_rise  = sclk_s & ~sclk_prev_q;
	assign sclk_fall  = ~sclk_s & sclk_prev_q;
	assign latch_rise = latch_s & ~latch_prev_q;

	assign active_d = sup_s & ~stby_s; // [R01] [R02] [R03]

	////////////////////////////////////////////////////////////////////////
	// serial link: shift in on rise, out on fall, latch loads readback
	always_comb begin
		shift_in_d  = shift_in_q;
		shift_out_d = shift_out_q;
		if (!active_d) begin
			// off or standby: frames dropped
			shift_in_d  = '0;  // [R01] [R03]
			shift_out_d = '0;
		end else begin
			if (sclk_rise) begin
				shift_in_d = {shift_in_q[22:0], sdi_s}; // [R11]
			end
			if (sclk_fall) begin
				shift_out_d = {shift_out_q[22:0], 1'b0}; // [R11]
			end
			if (latch_rise) begin
				shift_out_d = fault_word; // msb on the pin at once [R11]
			end
		end
		sdo_d = shift_out_d[23];
	end

	////////////////////////////////////////////////////////////////////////
	// register bank
	always_comb begin
		logic [17:0] clr;
		logic [31:0] wr;
		clr     = '0;
		wr      = byte_write({8'h00, setup_q}, avs_writedata, avs_byteenable);
		setup_d = setup_q;
		if (rd_fault) begin
			clr = rdata_q[23:6]; // bits the host has seen [R08]
		end
		if (latch_rise) begin
			clr = clr | flags_q; // serial readback reads too [R08]
		end
		if (!active_d) begin
			// defaults while off or in standby
			setup_d = led_regs_pkg::SETUP_RESET; // [R01] [R02] [R03]
			flags_d = led_regs_pkg::FLAG_RESET;  // [R03]
		end else begin
			if (latch_rise) begin
				setup_d = shift_in_q; // [R11]
			end else if (bus_acc && avs_write && bus_idx == led_regs_pkg::IDX_SETUP) begin
				setup_d = wr[23:0]; // [R07]
			end
			// set wins over clear
			flags_d = (flags_q & ~(clr & ~cause_v)) | cause_v; // [R08] [R10]
		end
		drain_d  = drain_eff;   // [R09]
		diag_d   = diag_eff;    // [R05]
		err_oe_d = |flags_q;    // pull fault pin low
	end

	////////////////////////////////////////////////////////////////////////
	// bus answer and interrupts
	always_comb begin
		logic [31:0] mw;
		logic [2:0]  ev;
		logic [2:0]  w1c;
		mw      = byte_write({29'h0, irq_mask_q}, avs_writedata, avs_byteenable);
		w1c     = '0;
		ev      = '0;
		waitreq_d = ~(bus_req & waitreq_q);
		rdata_d = rdata_q;
		if (bus_req && waitreq_q) begin
			case (bus_idx)
				led_regs_pkg::IDX_FAULT:      rdata_d = {8'h00, fault_word}; // [R07] [R10]
				led_regs_pkg::IDX_IRQ_STATUS: rdata_d = {29'h0, irq_status_q};
				led_regs_pkg::IDX_IRQ_MASK:   rdata_d = {29'h0, irq_mask_q};
				default:                      rdata_d = 32'h0000_0000; // setup write only, unmapped [R07]
			endcase
		end
		irq_mask_d = irq_mask_q;
		if (bus_acc && avs_write && bus_idx == led_regs_pkg::IDX_IRQ_MASK) begin
			irq_mask_d = mw[2:0];
		end
		if (bus_acc && avs_write && bus_idx == led_regs_pkg::IDX_IRQ_STATUS && avs_byteenable[0]) begin
			w1c = avs_writedata[2:0];
		end
		ev[led_regs_pkg::IRQ_FAULT_BIT] = |(flags_d & ~flags_q);
		ev[led_regs_pkg::IRQ_LATCH_BIT] = active_d & latch_rise;
		ev[led_regs_pkg::IRQ_DOWN_BIT]  = active_q & ~active_d;
		irq_status_d = (irq_status_q & ~w1c) | ev; // event wins over clear
		irq_d        = |(irq_status_d & irq_mask_d);
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			setup_q      <= led_regs_pkg::SETUP_RESET; // [R06]
			flags_q      <= led_regs_pkg::FLAG_RESET;
			active_q     <= 1'b0;
			shift_in_q   <= '0;
			shift_out_q  <= '0;
			sclk_prev_q  <= 1'b0;
			latch_prev_q <= 1'b0;
			waitreq_q    <= 1'b1;
			rdata_q      <= '0;
			irq_status_q <= '0;
			irq_mask_q   <= led_regs_pkg::MASK_RESET;
			irq          <= 1'b0;
			drain_q      <= '0;
			diag_q       <= '0;
			sdo_q        <= 1'b0;
			err_oe_q     <= 1'b0;
		end else begin
			setup_q      <= setup_d;
			flags_q      <= flags_d;
			active_q     <= active_d;
			shift_in_q   <= shift_in_d;
			shift_out_q  <= shift_out_d;
			sclk_prev_q  <= sclk_s;
			latch_prev_q <= latch_s;
			waitreq_q    <= waitreq_d;
			rdata_q      <= rdata_d;
			irq_status_q <= irq_status_d;
			irq_mask_q   <= irq_mask_d;
			irq          <= irq_d;
			drain_q      <= drain_d;
			diag_q       <= diag_d;
			sdo_q        <= sdo_d;
			err_oe_q     <= err_oe_d;
		end
	end

	// outputs straight from flops, fault_pin_o tied low
	assign avs_readdata     = rdata_q;
	assign avs_waitrequest  = waitreq_q;
	assign link_sdo         = sdo_q;
	assign output_switch_on = drain_q;
	assign diag_input_en    = diag_q;
	assign fault_pin_oe     = err_oe_q;
	assign fault_pin_o      = 1'b0; // open drain: only pulls low

	////////////////////////////////////////////////////////////////////////
	// checks
	power_state_a: assert property (@(posedge sys_clk) disable iff (rst) // [R01] [R02]
		!active_q |-> (setup_q == 24'h00_0000) && (flags_q == 18'h0_0000))
		else $error("registers not at default while inactive");

	standby_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // [R03]
		(sup_s && stby_s) |=> (flags_q == 18'h0_0000) && (shift_in_q == 24'h00_0000))
		else $error("standby did not restore defaults");

	pair_role_a: assert property (@(posedge sys_clk) disable iff (rst) // [R04] [R05]
		##1 diag_q == ($past(setup_q.pair_select) & ~$past(cmd_err_v)))
		else $error("pair role does not follow select bits");

	setup_reset_a: assert property (@(posedge sys_clk) // [R06]
		$fell(rst) |-> (setup_q == 24'h00_0000) ##1 (drain_q == 16'h0000))
		else $error("setup not zero after reset");

	two_regs_a: assert property (@(posedge sys_clk) disable iff (rst) // [R07]
		(bus_acc && avs_read && (bus_idx == 3'h0 || bus_idx > 3'h3)) |-> rdata_q == 32'h0000_0000)
		else $error("write only or unmapped read not zero");

	read_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // [R08]
		(rd_fault && active_d && !latch_rise) |=>
		(flags_q & $past(rdata_q[23:6]) & ~$past(cause_v)) == 18'h0_0000)
		else $error("read flag with fault gone not cleared");

	switch_follow_a: assert property (@(posedge sys_clk) disable iff (rst) // [R09]
		##1 drain_q == ($past(ot_s) ? 16'h0000 : $past(setup_q.output_switch)))
		else $error("output switches do not follow setup");

	flag_set_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
		(active_d && |cause_v) |=> (flags_q & $past(cause_v)) == $past(cause_v))
		else $error("live fault did not set its flag");

	frame_latch_a: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
		(latch_rise && active_d) |=> setup_q == $past(shift_in_q) ##1 link_sdo == $past(fault_word[23], 2))
		else $error("latch did not load frame or readback msb");

	odd_err_a: assert property (@(posedge sys_clk) disable iff (rst) // [R05]
		(active_d && |cmd_err_v) |=> flags_q[0])
		else $error("select with odd switch on did not flag error");

	bus_answer_a: assert property (@(posedge sys_clk) disable iff (rst) // [R07]
		(bus_req && waitreq_q) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle after request");

	fault_pin_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
		##1 fault_pin_oe == ($past(flags_q) != 18'h0_0000))
		else $error("fault pin does not follow flags");

endmodule : led_driver_regs

// *** tb/link_host.sv ***
// Purpose: host model driving the serial shift-and-latch link
// Assumes: paced by sys_clk, sclk period 25 cycles (125 ns)
// Notes:   sclk stands low between frames, sdi idles inverted
`timescale 1ns/1ps
module link_host (
	input  wire logic sys_clk,
	output logic      link_sclk,
	output logic      link_latch,
	output logic      link_sdi,
	input  wire logic link_sdo
);
	// idle pins at time zero
	initial begin
		link_sclk  = 1'b0;
		link_latch = 1'b0;
		link_sdi   = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// one frame msb first, then latch; rb collects readback bits
	task automatic send(input logic [23:0] w, output logic [23:0] rb);
		for (int i = 23; i >= 0; i--) begin
			link_sdi <= w[i];
			repeat (12) @(posedge sys_clk);
			rb[i] = link_sdo; // settled since last fall or latch
			link_sclk <= 1'b1;
			repeat (13) @(posedge sys_clk);
			link_sclk <= 1'b0;
		end
		repeat (12) @(posedge sys_clk);
		link_sdi   <= ~w[0]; // no stale bit on the idle line
		link_latch <= 1'b1;
		repeat (12) @(posedge sys_clk);
		link_latch <= 1'b0;
		repeat (12) @(posedge sys_clk);
	endtask : send
endmodule : link_host

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the led driver register bank
// Assumes: avalon answer after one cycle, link paced by host model
// Notes:   crc bits are masked out of flag comparisons, t_power checks the crc of one setup word
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk = 1'b0;      // 200 MHz
	logic        rst = 1'b1;          // sync reset
	logic [4:0]  avs_address = 5'h00; // byte address
	logic        avs_read = 1'b0;     // read request
	logic        avs_write = 1'b0;    // write request
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;        // read word
	logic        avs_waitrequest;     // low = done
	logic        supply_ok = 1'b1;    // supply good
	logic        standby_sel = 1'b0;  // standby pin
	logic        link_sclk, link_latch, link_sdi, link_sdo;
	logic [7:0]  led_open_det = 8'h00;
	logic [7:0]  led_short_det = 8'h00;
	logic        overtemp_det = 1'b0; // thermal detector
	logic [15:0] output_switch_on;    // channel switches
	logic [7:0]  diag_input_en;       // pair diag modes
	logic        fault_pin_o, fault_pin_oe, irq;
	logic [31:0] d;                   // last read word
	logic [23:0] rb;                  // serial readback
	int          fail_count = 0;
	int          n_checks = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////
	led_driver_regs u_led_driver_regs (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.supply_ok(supply_ok), .standby_sel(standby_sel), .link_sclk(link_sclk),
		.link_latch(link_latch), .link_sdi(link_sdi), .link_sdo(link_sdo),
		.led_open_det(led_open_det), .led_short_det(led_short_det), .overtemp_det(overtemp_det),
		.output_switch_on(output_switch_on), .diag_input_en(diag_input_en),
		.fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe), .irq(irq));
	link_host u_link_host (.sys_clk(sys_clk), .link_sclk(link_sclk), .link_latch(link_latch),
		.link_sdi(link_sdi), .link_sdo(link_sdo));
	// clock and hang guard
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			$display("Error at %0t: timeout", $time);
			fail_count++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// bus cycles: held until waitrequest sampled low
	task automatic bus_rd(input logic [4:0] a, output logic [31:0] v);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		v = avs_readdata;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask : bus_rd
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
		avs_address   <= a;
		avs_writedata <= v;
		avs_write     <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus_wr
	task automatic pause(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : pause
	////////////////////////////////////////////////////////////////
	// defaults and the map after reset
	task automatic t_reset;
		bus_rd(5'h04, d);
		chk(d, 32'h0000_0000);
		bus_rd(5'h00, d);
		chk(d, 32'h0000_0000);
		bus_wr(5'h10, 32'hffff_ffff);
		bus_rd(5'h10, d);
		chk(d, 32'h0000_0000);
		bus_rd(5'h0c, d);
		chk(d, 32'h0000_0000);
		chk({output_switch_on, diag_input_en, fault_pin_oe, irq, fault_pin_o}, 32'h0000_0000);
		$display("t_reset done");
	endtask : t_reset
	// serial setup word drives selects and switches
	task automatic t_setup;
		bus_wr(5'h0c, 32'h0000_0007);
		u_link_host.send(24'h81_0101, rb);
		pause(10);
		chk(diag_input_en, 32'h0000_0081);
		chk(output_switch_on, 32'h0000_0101);
		bus_rd(5'h08, d);
		chk(d & 32'h0000_0002, 32'h0000_0002);
		chk(irq, 32'h0000_0001);
		bus_wr(5'h08, 32'h0000_0002);
		pause(3);
		chk(irq, 32'h0000_0000);
		$display("t_setup done");
	endtask : t_setup
	// open flag sticks until read with cause gone
	task automatic t_open;
		led_open_det <= 8'h01;
		pause(10);
		chk(fault_pin_oe, 32'h0000_0001);
		bus_rd(5'h04, d);
		chk(d & 32'hffff_ffc0, 32'h0000_0200);
		led_open_det <= 8'h00;
		pause(10);
		bus_rd(5'h04, d);
		chk(d & 32'hffff_ffc0, 32'h0000_0200);
		bus_rd(5'h04, d);
		chk(d & 32'hffff_ffc0, 32'h0000_0000);
		chk(irq, 32'h0000_0001);
		bus_wr(5'h08, 32'h0000_0001);
		pause(3);
		chk(irq, 32'h0000_0000);
		$display("t_open done");
	endtask : t_open
	// select with odd switch on: plain output, error flag
	task automatic t_cmd;
		repeat (3) u_link_host.send(24'h01_0002, rb);
		pause(10);
		chk(rb[6], 32'h0000_0001);
		chk(output_switch_on, 32'h0000_0002);
		chk(diag_input_en, 32'h0000_0000);
		bus_rd(5'h04, d);
		chk(d & 32'h0000_0040, 32'h0000_0040);
		$display("t_cmd done");
	endtask : t_cmd
	// overtemperature forces switches off and flags
	task automatic t_hot;
		overtemp_det <= 1'b1;
		pause(10);
		chk(output_switch_on, 32'h0000_0000);
		bus_rd(5'h04, d);
		chk(d & 32'h0000_0080, 32'h0000_0080);
		overtemp_det <= 1'b0;
		pause(10);
		$display("t_hot done");
	endtask : t_hot
	// supply loss and standby both return defaults
	task automatic t_power;
		bus_wr(5'h00, 32'h00d7_0f68);
		bus_rd(5'h04, d);
		chk(d & 32'h0000_003f, 32'h0000_0019);
		for (int k = 0; k < 2; k++) begin
			bus_wr(5'h00, 32'h0000_0003);
			pause(3);
			chk(output_switch_on, 32'h0000_0003);
			if (k == 0) supply_ok <= 1'b0;
			else standby_sel <= 1'b1;
			pause(10);
			chk(output_switch_on, 32'h0000_0000);
			bus_rd(5'h04, d);
			chk(d, 32'h0000_0000);
			supply_ok   <= 1'b1;
			standby_sel <= 1'b0;
			pause(10);
			chk(output_switch_on, 32'h0000_0000);
			bus_rd(5'h08, d);
			chk(d & 32'h0000_0004, 32'h0000_0004);
			bus_wr(5'h08, 32'h0000_0007);
		end
		// mid-run reset returns the setup word to zero
		bus_wr(5'h00, 32'h0000_0005);
		pause(2);
		chk(output_switch_on, 32'h0000_0005);
		rst <= 1'b1;
		pause(3);
		rst <= 1'b0;
		pause(5);
		chk(output_switch_on, 32'h0000_0000);
		bus_rd(5'h04, d);
		chk(d, 32'h0000_0000);
		$display("t_power done");
	endtask : t_power
	////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	// main sequence
	initial begin
		pause(3);
		rst <= 1'b0;
		pause(4);
		t_reset();
		t_setup();
		t_open();
		t_cmd();
		t_hot();
		t_power();
		conclude();
	end
endmodule : tb_top
